// [verilog/tct_params.svh]
// offsets, field positions, reset values and timing counts of the throttle
`ifndef TCT_PARAMS_SVH
`define TCT_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TCT_OFF_CTRL 12'h000
`define TCT_OFF_STATUS 12'h004
`define TCT_OFF_THRESH 12'h008

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define TCT_CTRL_RST 8'h01
`define TCT_C_AUTO 0
`define TCT_C_DUTY_LO 1
`define TCT_C_DUTY_HI 3
`define TCT_C_DEMAND 4
`define TCT_C_RISE_IE 5
`define TCT_C_FALL_IE 6
`define TCT_C_OOS_IE 7

// ----------------------------------------------------------------
// status register fields (bits 4..8 are write-one-to-clear)
// ----------------------------------------------------------------
`define TCT_S_HOT 0
`define TCT_S_THROTTLE 1
`define TCT_S_CLK_ON 2
`define TCT_S_OOS 3
`define TCT_S_OOS_STICKY 4
`define TCT_S_RISE_LOG 5
`define TCT_S_FALL_LOG 6
`define TCT_S_THR_LOG 7
`define TCT_S_VALID 9
`define TCT_S_TEMP_LO 16
`define TCT_W1C_MASK 9'h1f0

// ----------------------------------------------------------------
// threshold register: two 8-bit slots, value in 6:0, enable in 7
// ----------------------------------------------------------------
`define TCT_THRESH_RST 16'h0000
`define TCT_THR_SLOT 8
`define TCT_THR_EN 7

// ----------------------------------------------------------------
// temperature and ratio constants
// ----------------------------------------------------------------
`define TCT_TEMP_W 7
`define TCT_HYST 7'd2
`define TCT_AUTO_ON 3'd4
`define TCT_CAT_TEMP_C 125

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TCT_CLK_NS 10
`define TCT_SLOT_NS 40
`define TCT_SLOT_CYC ((`TCT_SLOT_NS + `TCT_CLK_NS - 1) / `TCT_CLK_NS)
`define TCT_OOS_NS 10000
`define TCT_OOS_CYC (`TCT_OOS_NS / `TCT_CLK_NS)

`endif

// [verilog/tct_pkg.sv]
// types shared by the thermal clock throttle
package tct_pkg;

   typedef enum logic [1:0] {TM_OFF, TM_AUTO, TM_DEMAND} tct_mode_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } tct_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tct_apb_rsp_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic [2:0] phase;
      logic clk_on;
   } tct_duty_st_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [15:0] thresh;
      logic trip;
      logic hot;
      logic pin_q;
      logic oos;
      logic oos_sticky;
      logic rise_log;
      logic fall_log;
      logic [1:0] thr_log;
      logic [1:0] thr_below;
      logic [11:0] oos_cnt;
      logic cat;
      logic irq_pend;
      logic thermal_irq;
      logic [31:0] prdata;
      logic pslverr;
      tct_mode_t mode;
   } tct_st_t;

endpackage : tct_pkg

// [verilog/tct_duty_gen.sv]
// slot-based duty generator for the core clock enable
`timescale 1ns/1ns
`default_nettype none
`include "tct_params.svh"

module tct_duty_gen #(
   parameter int SLOT_CYC = `TCT_SLOT_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic active,
   input wire logic [2:0] on_slots,
   // gated clock enable
   output logic clk_on
);
   import tct_pkg::*;

   tct_duty_st_t st_ff;
   tct_duty_st_t nxt_st;
   logic [2:0] nxt_phase;

   // ----------------------------------------------------------------
   // eight slots per period, the first on_slots of them run the core
   // ----------------------------------------------------------------
   // while active, enable only moves at slot ends, so no partial slot reaches the core
   always_comb
   begin
      nxt_st = st_ff;
      nxt_phase = st_ff.phase + 3'd1;
      if (!active)
      begin
         nxt_st.cnt = 8'h00;
         nxt_st.phase = 3'h0;
         nxt_st.clk_on = 1'b1;
      end
      else if (st_ff.cnt == 8'(SLOT_CYC - 1))
      begin
         nxt_st.cnt = 8'h00;
         nxt_st.phase = nxt_phase;
         nxt_st.clk_on = (nxt_phase < on_slots);
      end
      else
      begin
         nxt_st.cnt = st_ff.cnt + 8'h01;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= '{cnt: 8'h00, phase: 3'h0, clk_on: 1'b1};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign clk_on = st_ff.clk_on;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // enable flips only on a slot boundary while throttling
   a_slot_whole: assert property (
      ($changed(st_ff.clk_on) && $past(active) && active)
         |-> st_ff.cnt == 8'h00)
      else $error("clock enable changed inside a slot");

endmodule : tct_duty_gen
`default_nettype wire

// [verilog/tct_top.sv]
// thermal clock throttle: trip detect, duty modulation, hot pin, apb regs
//
// Function
// - auto throttle engages at the fixed, non-programmable trip point or on an external low on the hot pin
// - snooping continues; interrupts latched and delivered only in on-phases
// - auto mode wins over on-demand when both apply
// - auto mode modulates clocks at a fixed 50 percent ratio
// - throttle ends once temperature returns to a safe level
// - hysteresis around trip point prevents rapid toggling
// - on-demand bit 4 starts throttling at once, any temperature
// - on-demand ratio from bits 3:1 in 12.5 percent steps
// - hot pin driven low while die is above trip point
// - optional interrupt on asserting or deasserting edge of hot pin
// - hot pin not newly asserted in low-power states
// - hot pin kept asserted through low-power state if already asserted
// - catastrophic trip asserts and core shuts down near 125 C
// - catastrophic trip independent of activity, issues no bus cycle
// - sensor reports offset below junction limit, never above it
// - sensor reading valid only in full-run state
// - sensor reaching maximum triggers auto throttle at that point
// - persistent heat under auto throttle latches out-of-spec and sticky
// - two programmable thresholds each raise an interrupt when crossed
// - external low on hot pin requests throttling
`timescale 1ns/1ns
`default_nettype none
`include "tct_params.svh"

module tct_top #(
   parameter int OOS_CYC = `TCT_OOS_CYC,
   parameter int SLOT_CYC = `TCT_SLOT_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire tct_pkg::tct_apb_req_t apb_req,
   output tct_pkg::tct_apb_rsp_t apb_rsp,
   // on-die sensor: offset below the junction limit
   input wire logic [`TCT_TEMP_W-1:0] temp_offset,
   input wire logic temp_valid,
   input wire logic full_run_state,
   input wire logic low_power_state,
   input wire logic cat_temp_hit,
   // hot indication open-drain pin
   input wire logic hot_indication_n_i,
   output logic hot_indication_n_o,
   output logic hot_indication_n_oe,
   // core side
   output logic core_clk_en,
   output logic core_shutdown,
   output logic catastrophic_trip_n,
   input wire logic snoop_req,
   output logic snoop_go,
   input wire logic ext_irq_req,
   output logic core_irq,
   input wire logic core_irq_ack,
   // to the local interrupt controller
   output logic thermal_irq
);
   import tct_pkg::*;

   localparam int NTHR = 2;

   tct_st_t st_ff;
   tct_st_t nxt_st;
   logic clk_on;
   logic [2:0] on_slots;
   logic pin_low;
   logic at_max;
   logic cool;
   logic sense_ok;
   logic auto_act;
   logic rise_evt;
   logic fall_evt;
   logic oos_evt;
   logic [NTHR-1:0] thr_evt;
   logic [NTHR-1:0] thr_now;
   logic [NTHR-1:0] thr_irq;
   logic [8:0] w1c;
   logic wr_acc;
   logic rd_setup;

   // ----------------------------------------------------------------
   // address decode, shared by read and write paths
   // ----------------------------------------------------------------
   function automatic logic [1:0] reg_idx(input logic [11:0] a);
      logic [1:0] r;
      r = 2'd3;
      if (a == `TCT_OFF_CTRL)
      begin
         r = 2'd0;
      end
      else if (a == `TCT_OFF_STATUS)
      begin
         r = 2'd1;
      end
      else if (a == `TCT_OFF_THRESH)
      begin
         r = 2'd2;
      end
      return r;
   endfunction : reg_idx

   // ----------------------------------------------------------------
   // threshold crossing detectors
   // ----------------------------------------------------------------
   // a crossing is either direction; compared only on a valid reading
   for (genvar i = 0; i < NTHR; i++)
   begin : g_thr
      assign thr_now[i] = temp_offset <=
         st_ff.thresh[i*`TCT_THR_SLOT +: `TCT_TEMP_W];
      assign thr_evt[i] = sense_ok &&
         (thr_now[i] != st_ff.thr_below[i]);
      assign thr_irq[i] = thr_evt[i] &&
         st_ff.thresh[i*`TCT_THR_SLOT + `TCT_THR_EN];
   end

   // ----------------------------------------------------------------
   // sensing and event terms
   // ----------------------------------------------------------------
   // readings outside full-run are ignored and the old state holds
   assign sense_ok = temp_valid && full_run_state;
   assign at_max = (temp_offset == '0);
   assign cool = (temp_offset >= `TCT_HYST);
   assign pin_low = !hot_indication_n_i;
   assign auto_act = st_ff.ctrl[`TCT_C_AUTO] &&
      (st_ff.trip || pin_low);
   assign rise_evt = pin_low && !st_ff.pin_q;
   assign fall_evt = !pin_low && st_ff.pin_q;
   // one event per episode: the counter parks at its end value once set
   assign oos_evt = auto_act && st_ff.trip && !st_ff.oos &&
      (st_ff.oos_cnt == 12'(OOS_CYC - 1));
   assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_setup = apb_req.psel && !apb_req.penable;
   assign w1c = (wr_acc && reg_idx(apb_req.paddr) == 2'd1) ?
      apb_req.pwdata[8:0] & `TCT_W1C_MASK : 9'h000;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.thermal_irq = 1'b0;
      // trip with hysteresis: set at the maximum, clear once cooled
      if (sense_ok)
      begin
         if (at_max)
         begin
            nxt_st.trip = 1'b1;
         end
         else if (cool)
         begin
            nxt_st.trip = 1'b0;
         end
      end
      // low-power states freeze the pin: no new assertion, no release
      if (!low_power_state)
      begin
         nxt_st.hot = st_ff.trip;
      end
      nxt_st.pin_q = pin_low;
      // mode select: auto outranks on-demand
      if (auto_act)
      begin
         nxt_st.mode = TM_AUTO;
      end
      else if (st_ff.ctrl[`TCT_C_DEMAND])
      begin
         nxt_st.mode = TM_DEMAND;
      end
      else
      begin
         nxt_st.mode = TM_OFF;
      end
      // out-of-spec timer runs while auto throttling cannot cool the die
      if (auto_act && st_ff.trip)
      begin
         if (!oos_evt && !st_ff.oos)
         begin
            nxt_st.oos_cnt = st_ff.oos_cnt + 12'h001;
         end
         if (oos_evt)
         begin
            nxt_st.oos = 1'b1;
         end
      end
      else
      begin
         nxt_st.oos_cnt = 12'h000;
         nxt_st.oos = 1'b0;
      end
      // sticky logs: a set in the clearing cycle wins
      nxt_st.oos_sticky = (st_ff.oos_sticky && !w1c[`TCT_S_OOS_STICKY]) ||
         oos_evt;
      nxt_st.rise_log = (st_ff.rise_log && !w1c[`TCT_S_RISE_LOG]) ||
         rise_evt;
      nxt_st.fall_log = (st_ff.fall_log && !w1c[`TCT_S_FALL_LOG]) ||
         fall_evt;
      nxt_st.thr_log = (st_ff.thr_log &
         ~w1c[`TCT_S_THR_LOG +: NTHR]) | thr_evt;
      if (sense_ok)
      begin
         nxt_st.thr_below = thr_now;
      end
      // thermal interrupt pulse to the local interrupt controller
      nxt_st.thermal_irq =
         (rise_evt && st_ff.ctrl[`TCT_C_RISE_IE]) ||
         (fall_evt && st_ff.ctrl[`TCT_C_FALL_IE]) ||
         (oos_evt && st_ff.ctrl[`TCT_C_OOS_IE]) ||
         (|thr_irq);
      // catastrophic trip latches until reset, whatever the modes
      nxt_st.cat = st_ff.cat || cat_temp_hit;
      // incoming interrupt held until the core takes it in an on-phase
      nxt_st.irq_pend = (st_ff.irq_pend && !(core_irq && core_irq_ack)) ||
         ext_irq_req;
      // register writes land at the access edge
      if (wr_acc && reg_idx(apb_req.paddr) == 2'd0)
      begin
         nxt_st.ctrl = apb_req.pwdata[7:0];
      end
      if (wr_acc && reg_idx(apb_req.paddr) == 2'd2)
      begin
         nxt_st.thresh = apb_req.pwdata[15:0];
      end
      // read data captured in the setup phase, valid through the access
      if (rd_setup)
      begin
         nxt_st.pslverr = (reg_idx(apb_req.paddr) == 2'd3);
         case (reg_idx(apb_req.paddr))
            2'd0: nxt_st.prdata = {24'h000000, st_ff.ctrl};
            2'd1: nxt_st.prdata = {9'h000, temp_offset, 6'h00,
               sense_ok, st_ff.thr_log, st_ff.fall_log, st_ff.rise_log,
               st_ff.oos_sticky, st_ff.oos, clk_on,
               st_ff.mode != TM_OFF, pin_low};
            2'd2: nxt_st.prdata = {16'h0000, st_ff.thresh};
            default: nxt_st.prdata = 32'h00000000;
         endcase
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= '{ctrl: `TCT_CTRL_RST, thresh: `TCT_THRESH_RST,
            mode: TM_OFF, default: '0};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // duty ratio and modulator
   // ----------------------------------------------------------------
   // on-demand field 0 is undefined; it falls back to half duty
   always_comb
   begin
      case (st_ff.mode)
         TM_AUTO: on_slots = `TCT_AUTO_ON;
         TM_DEMAND: on_slots =
            (st_ff.ctrl[`TCT_C_DUTY_HI:`TCT_C_DUTY_LO] == 3'h0) ?
            `TCT_AUTO_ON : st_ff.ctrl[`TCT_C_DUTY_HI:`TCT_C_DUTY_LO];
         default: on_slots = `TCT_AUTO_ON;
      endcase
   end

   tct_duty_gen #(
      .SLOT_CYC(SLOT_CYC)
   ) u_duty (
      .pclk(pclk),
      .presetn(presetn),
      .active(st_ff.mode != TM_OFF),
      .on_slots(on_slots),
      .clk_on(clk_on)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // snoops bypass the throttle; the core sees interrupts only when clocked
   assign core_clk_en = clk_on && !st_ff.cat;
   assign snoop_go = snoop_req;
   assign core_irq = st_ff.irq_pend && core_clk_en;
   assign core_shutdown = st_ff.cat;
   assign catastrophic_trip_n = !st_ff.cat;
   assign hot_indication_n_o = 1'b0;
   assign hot_indication_n_oe = st_ff.hot;
   assign thermal_irq = st_ff.thermal_irq;
   assign apb_rsp = '{prdata: st_ff.prdata, pready: 1'b1,
      pslverr: st_ff.pslverr};

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_max_seen;
      sense_ok && at_max && !low_power_state;
   endsequence
   sequence s_run_on;
      !low_power_state;
   endsequence

   a_auto_needs_heat: assert property (
      $rose(st_ff.mode == TM_AUTO) |->
         $past(st_ff.ctrl[`TCT_C_AUTO]) && $past(st_ff.trip || pin_low))
      else $error("auto throttle without trip or pin request");
   a_auto_half_duty: assert property (
      (st_ff.mode == TM_AUTO) |-> on_slots == `TCT_AUTO_ON)
      else $error("auto mode not at half duty");
   a_demand_ratio: assert property (
      (st_ff.mode == TM_DEMAND && st_ff.ctrl[3:1] != 3'h0)
         |-> on_slots == st_ff.ctrl[3:1])
      else $error("on-demand ratio not taken from control");
   a_demand_starts: assert property (
      (wr_acc && apb_req.paddr == `TCT_OFF_CTRL && apb_req.pwdata[4]
         && !auto_act) |=> ##1 st_ff.mode == TM_DEMAND)
      else $error("on-demand write did not start throttle");
   a_idle_clock_on: assert property (
      (st_ff.mode == TM_OFF) |=> core_clk_en == !st_ff.cat)
      else $error("core clock gated while not throttling");
   a_hyst_hold: assert property (
      (st_ff.trip && sense_ok && !cool) |=> st_ff.trip)
      else $error("trip released inside hysteresis band");
   a_hot_follows: assert property (
      s_max_seen ##1 s_run_on |=> hot_indication_n_oe)
      else $error("hot pin not driven after trip");
   a_lp_no_new: assert property (
      (low_power_state && !st_ff.hot) |=> !hot_indication_n_oe)
      else $error("hot pin newly asserted in low power");
   a_lp_hold: assert property (
      (low_power_state && st_ff.hot) |=> hot_indication_n_oe)
      else $error("hot pin dropped in low power");
   a_cat_latch: assert property (
      cat_temp_hit |=> (!catastrophic_trip_n && !core_clk_en)[*3])
      else $error("catastrophic trip not latched");
   a_oos_sticky: assert property (
      $rose(st_ff.oos) |-> st_ff.oos_sticky &&
         $past(st_ff.oos_cnt) == 12'(OOS_CYC - 1))
      else $error("out-of-spec set without sticky or early");
   a_irq_gated: assert property (
      ext_irq_req |=> st_ff.irq_pend && (core_irq == core_clk_en))
      else $error("interrupt lost or delivered in off phase");
   a_thr_event: assert property (
      (thr_evt[0] && st_ff.thresh[`TCT_THR_EN])
         |=> thermal_irq && st_ff.thr_log[0])
      else $error("threshold crossing raised no interrupt");

endmodule : tct_top
`default_nettype wire

// [testbench/tct_board.sv]
// board model: pulled-up hot pin, cooling agent and core supply cut-off
`timescale 1ns/1ns
`default_nettype none

module tct_board (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // hot indication pin
   input wire logic pin_o,
   input wire logic pin_oe,
   input wire logic ext_hot,
   output logic pin_n,
   // catastrophic trip and core supply
   input wire logic catastrophic_trip_n,
   output logic supply_on
);
   logic supply_on_ff;

   // pull-up wins unless the die or the regulator agent pulls low
   assign pin_n = ((pin_oe && !pin_o) || ext_hot) ? 1'b0 : 1'b1;

   // supply is dropped on the first edge that sees the trip
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         supply_on_ff <= 1'b1;
      else if (!catastrophic_trip_n)
         supply_on_ff <= 1'b0;
   end
   assign supply_on = supply_on_ff;
endmodule : tct_board
`default_nettype wire

// [testbench/tb_thermal_clock_throttle.sv]
// self-checking testbench for the thermal clock throttle
`timescale 1ns/1ns
`default_nettype none
`include "tct_params.svh"

module tb_thermal_clock_throttle;
   import tct_pkg::*;
   // ----------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   tct_apb_req_t req = '0;
   tct_apb_rsp_t rsp;
   logic [6:0] toff = 7'h7f;
   logic frun = 1'b1;
   logic lowp = 1'b0;
   logic cat = 1'b0;
   logic ext = 1'b0;
   logic snp = 1'b1;
   logic irq_in = 1'b0;
   logic ack = 1'b1;
   logic pin_n, oe, pin_o, clk_en, shut, trip_n, snoop_go, core_irq;
   logic therm_irq, supply, serr;
   logic [31:0] rd;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_irq = 0;
   int got;

   always #5 pclk = ~pclk;

   // thermal event pulses counted away from the launching edge
   always @(negedge pclk)
      if (therm_irq === 1'b1)
         n_irq++;

   tct_top #(.OOS_CYC(20), .SLOT_CYC(4)) u_tct_top (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .temp_offset(toff), .temp_valid(1'b1), .full_run_state(frun),
      .low_power_state(lowp), .cat_temp_hit(cat),
      .hot_indication_n_i(pin_n), .hot_indication_n_o(pin_o),
      .hot_indication_n_oe(oe), .core_clk_en(clk_en),
      .core_shutdown(shut), .catastrophic_trip_n(trip_n),
      .snoop_req(snp), .snoop_go(snoop_go), .ext_irq_req(irq_in),
      .core_irq(core_irq), .core_irq_ack(ack), .thermal_irq(therm_irq));

   tct_board u_tct_board (
      .pclk(pclk), .presetn(presetn), .pin_o(pin_o), .pin_oe(oe),
      .ext_hot(ext), .pin_n(pin_n), .catastrophic_trip_n(trip_n),
      .supply_on(supply));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      req <= '{paddr:a, psel:1'b1, penable:1'b0, pwrite:w, pwdata:d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do
         @(posedge pclk);
      while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      serr = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic rdm(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask : rdm

   task automatic waitc(input int n);
      repeat (n) @(posedge pclk);
   endtask : waitc

   task automatic temp(input logic [6:0] v);
      @(posedge pclk);
      toff <= v;
   endtask : temp

   // count enabled cycles over one full 8-slot frame
   task automatic duty(input int e);
      got = 0;
      repeat (32) @(negedge pclk) got += (clk_en === 1'b1);
      chk(got, e);
   endtask : duty

   task automatic wrap_up;
      $display("mismatches %0d checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------
   // watchdog: whole run needs well under 5000 cycles
   // ----------------------------------------------------------
   initial
   begin
      #100000;
      n_mismatch++;
      wrap_up();
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdm(`TCT_OFF_CTRL, 32'hff, 32'h01);
      rdm(`TCT_OFF_THRESH, 32'hffff, 32'h0);
      rdm(12'h00c, 32'hffffffff, 32'h0);
      chk(serr, 1'b1);
      // automatic throttle with edge and out-of-spec events enabled
      apb(1'b1, `TCT_OFF_CTRL, 32'he1);
      temp(7'h00);
      waitc(40);
      chk(oe, 1'b1);
      rdm(`TCT_OFF_STATUS, 32'h1b, 32'h1b);
      chk(n_irq, 2);
      duty(16);
      // latched request shows only in on-phases; snoops never stall
      @(posedge pclk);
      irq_in <= 1'b1;
      @(posedge pclk);
      irq_in <= 1'b0;
      got = 0;
      repeat (40)
      begin
         @(negedge pclk);
         if (core_irq === 1'b1)
         begin
            got++;
            chk(clk_en, 1'b1);
         end
         chk(snoop_go, 1'b1);
      end
      chk(got, 1);
      temp(7'h01);
      waitc(12);
      rdm(`TCT_OFF_STATUS, 32'h2, 32'h2);
      temp(7'h0a);
      waitc(40);
      duty(32);
      chk(n_irq, 3);
      rdm(`TCT_OFF_STATUS, 32'h70, 32'h70);
      apb(1'b1, `TCT_OFF_STATUS, 32'h1f0);
      rdm(`TCT_OFF_STATUS, 32'h70, 32'h0);
      // on-demand ratios, then auto taking over while hot
      for (int d = 1; d < 8; d++)
      begin
         apb(1'b1, `TCT_OFF_CTRL, 32'h11 | (d << 1));
         waitc(10);
         duty(4 * d);
      end
      temp(7'h00);
      waitc(40);
      duty(16);
      temp(7'h0a);
      apb(1'b1, `TCT_OFF_CTRL, 32'h01);
      waitc(40);
      // threshold crossing in both directions
      apb(1'b1, `TCT_OFF_THRESH, 32'h85);
      apb(1'b1, `TCT_OFF_STATUS, 32'h1f0);
      temp(7'h03);
      waitc(5);
      chk(n_irq, 4);
      rdm(`TCT_OFF_STATUS, 32'h180, 32'h80);
      temp(7'h0a);
      waitc(5);
      chk(n_irq, 5);
      // external agent asks for cooling
      @(posedge pclk);
      ext <= 1'b1;
      waitc(10);
      duty(16);
      rdm(`TCT_OFF_STATUS, 32'h3, 32'h3);
      ext <= 1'b0;
      waitc(40);
      // pin already driven on low-power entry stays driven until exit
      temp(7'h00);
      waitc(5);
      lowp <= 1'b1;
      temp(7'h0a);
      waitc(10);
      chk(oe, 1'b1);
      lowp <= 1'b0;
      waitc(3);
      chk(oe, 1'b0);
      waitc(10);
      // low-power entry while cool: pin must stay released
      lowp <= 1'b1;
      temp(7'h00);
      waitc(20);
      chk(oe, 1'b0);
      temp(7'h0a);
      lowp <= 1'b0;
      waitc(20);
      // reading ignored outside full run
      frun <= 1'b0;
      temp(7'h00);
      waitc(20);
      rdm(`TCT_OFF_STATUS, 32'h202, 32'h0);
      temp(7'h0a);
      frun <= 1'b1;
      waitc(20);
      // catastrophic trip
      @(posedge pclk);
      cat <= 1'b1;
      @(posedge pclk);
      cat <= 1'b0;
      waitc(2);
      @(negedge pclk);
      chk({trip_n, shut, clk_en}, 3'b010);
      chk(supply, 1'b0);
      wrap_up();
   end
endmodule : tb_thermal_clock_throttle
`default_nettype wire
